// *** include/boot_cfg_pkg.sv ***
// constants shared by the strap, reset and clock-enable logic
package boot_cfg_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned RESET_HOLD_NS = 1000;
    localparam int unsigned RESET_HOLD_CYCLES = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CPU_DIV = 2;
    localparam int unsigned BUS_DIV = 2;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] PLL_SETUP_ADDR = 32'hA090_0188;
    localparam logic [31:0] IDENTITY_ADDR = 32'hA090_0210;
    localparam logic [31:0] REMAP_CTRL_ADDR = 32'hA090_0214;
    localparam logic [31:0] RESET_CAUSE_ADDR = 32'hA090_0218;
    // ------------------------------------------------------------
    // address strap layout
    // ------------------------------------------------------------
    localparam int unsigned STRAP_W = 20;
    localparam int unsigned REF_STRAP_LSB = 0;
    localparam int unsigned OUT_STRAP_LSB = 5;
    localparam int unsigned PLL_MODE_STRAP = 7;
    localparam int unsigned VARIANT_STRAP_LSB = 9;
    localparam int unsigned PLATFORM_STRAP_LSB = 13;
    localparam int unsigned MEMCFG_STRAP_LSB = 17;
    localparam logic [4:0] REF_STRAP_XOR = 5'h18;
    // ------------------------------------------------------------
    // identity register fields
    // ------------------------------------------------------------
    localparam int unsigned ID_PLATFORM_LSB = 4;
    localparam int unsigned ID_VARIANT_LSB = 8;
    localparam int unsigned ID_MEMCFG_LSB = 12;
    // ------------------------------------------------------------
    // pll_setup fields and reset value
    // ------------------------------------------------------------
    localparam int unsigned PLL_REF_LSB = 0;
    localparam int unsigned PLL_OUT_LSB = 5;
    localparam int unsigned PLL_NORMAL_BIT = 7;
    localparam int unsigned PLL_MULT_LSB = 8;
    localparam logic [7:0] MULT_RESET = 8'h3C;
    // ------------------------------------------------------------
    // control and cause fields, memory map bases
    // ------------------------------------------------------------
    localparam int unsigned REMAP_BIT = 0;
    localparam int unsigned CAUSE_HARD = 0;
    localparam int unsigned CAUSE_SOFT = 1;
    localparam int unsigned CAUSE_PLL = 2;
    localparam int unsigned CAUSE_WDOG = 3;
    localparam logic [31:0] FLASH_BOOT_BASE = 32'h0000_0000;
    localparam logic [31:0] FLASH_RUN_BASE = 32'h5000_0000;
endpackage

// *** include/cfg_if.sv ***
// carrier between strap sampler, enable divider and the core
`timescale 1ns/1ps
interface cfg_if;
    logic strap_valid;
    logic [boot_cfg_pkg::STRAP_W-1:0] addr_strap;
    logic byte_order;
    logic debug_sel;
    logic soft_n;
    logic wdog;
    logic iface_en;
    logic cpu_en;
    logic bus_en;
    modport sampler (output strap_valid, addr_strap, byte_order, debug_sel, soft_n, wdog);
    modport divider (output iface_en, cpu_en, bus_en);
    modport core (input strap_valid, addr_strap, byte_order, debug_sel, soft_n, wdog,
        iface_en, cpu_en, bus_en);
endinterface

// *** logic/strap_sampler.sv ***
// pin synchronisers and strap capture after hard reset
`timescale 1ns/1ps
module strap_sampler (
    // clock and hard reset
    input wire logic clk,
    input wire logic rst,
    // board pins
    input wire logic [boot_cfg_pkg::STRAP_W-1:0] addr_pins,
    input wire logic byte_order_pin,
    input wire logic debug_sel_pin,
    input wire logic soft_n_pin,
    input wire logic wdog_pin,
    // towards the core
    cfg_if.sampler cfg
);
    localparam int unsigned N = boot_cfg_pkg::STRAP_W + 4;
    logic [N-1:0] pins;
    logic [N-1:0] meta;
    logic [N-1:0] sync;
    logic taken;

    assign pins = {wdog_pin, soft_n_pin, debug_sel_pin, byte_order_pin, addr_pins};

    // two flops per pin; first stage feeds only the second
    for (genvar i = 0; i < N; i++) begin : g_sync
        always_ff @(posedge clk) begin
            meta[i] <= pins[i];
            sync[i] <= meta[i];
        end
    end

    // live control pins pass straight on once synchronised
    assign cfg.soft_n = sync[N-2];
    assign cfg.wdog = sync[N-1];

    // straps caught once, after release of the hard reset only
    always_ff @(posedge clk) begin
        if (rst) begin
            taken <= 1'b0;
            cfg.strap_valid <= 1'b0;
            cfg.addr_strap <= '0;
            cfg.byte_order <= 1'b0;
            cfg.debug_sel <= 1'b0;
        end else if (!taken) begin
            taken <= 1'b1;
            cfg.strap_valid <= 1'b1;
            cfg.addr_strap <= sync[boot_cfg_pkg::STRAP_W-1:0];
            cfg.byte_order <= sync[N-4];
            cfg.debug_sel <= sync[N-3];
        end
    end
endmodule

// *** logic/clock_enable_divider.sv ***
// enable pulses for interface, processor and system bus rates
`timescale 1ns/1ps
module clock_enable_divider #(
    parameter int unsigned CPU_DIV = boot_cfg_pkg::CPU_DIV,
    parameter int unsigned BUS_DIV = boot_cfg_pkg::BUS_DIV
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // enables out
    cfg_if.divider cfg
);
    logic [7:0] cpu_cnt;
    logic [7:0] bus_cnt;

    // processor rate is the pll rate over CPU_DIV, bus over BUS_DIV more
    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_cnt <= '0;
            bus_cnt <= '0;
            cfg.iface_en <= 1'b0;
            cfg.cpu_en <= 1'b0;
            cfg.bus_en <= 1'b0;
        end else begin
            cfg.iface_en <= 1'b1;
            cfg.cpu_en <= (cpu_cnt == 8'(CPU_DIV - 1));
            cfg.bus_en <= (cpu_cnt == 8'(CPU_DIV - 1)) && (bus_cnt == 8'(BUS_DIV - 1));
            if (cpu_cnt == 8'(CPU_DIV - 1)) begin
                cpu_cnt <= '0;
                bus_cnt <= (bus_cnt == 8'(BUS_DIV - 1)) ? 8'h00 : bus_cnt + 8'h01;
            end else begin
                cpu_cnt <= cpu_cnt + 8'h01;
            end
        end
    end
endmodule

// *** logic/boot_strap_and_reset_config.sv ***
// strap capture, identity and pll registers, reset sequencing, boot remap
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps

module boot_strap_and_reset_config (
    // clock and hard reset pin
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // board straps and reset sources
    input wire logic [boot_cfg_pkg::STRAP_W-1:0] ADDR_STRAP,
    input wire logic BYTE_ORDER_STRAP,
    input wire logic DEBUG_MODE_SELECT,
    input wire logic SOFT_RESET_PIN_N,
    input wire logic WATCHDOG_TIMEOUT,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // boot configuration outputs
    output logic BIG_ENDIAN,
    output logic DEBUG_MODE,
    output logic SCAN_TEST_ENABLE,
    output logic [4:0] REF_DIVIDER,
    output logic [1:0] OUTPUT_DIVIDER,
    output logic PLL_NORMAL,
    output logic [7:0] FEEDBACK_MULTIPLIER,
    // reset and memory map outputs
    output logic INTERNAL_RESET,
    output logic SDRAM_RETAIN,
    output logic PINMUX_RESET,
    output logic BOOT_REMAP,
    output logic [31:0] FLASH_BASE,
    // derived rate enables
    output logic IFACE_CLK_EN,
    output logic CPU_CLK_EN,
    output logic BUS_CLK_EN
);
    // ------------------------------------------------------------
    // local types and signals
    // ------------------------------------------------------------
    typedef enum {RUNNING, HOLDING} reset_state_type;

    localparam int unsigned HOLD_CYCLES = boot_cfg_pkg::RESET_HOLD_CYCLES;

    cfg_if cfg ();

    reset_state_type state;
    logic [15:0] hold_count;
    logic retain;
    logic wdog_q;
    logic soft_req;
    logic wdog_req;
    logic pll_req;
    logic any_req;
    logic ctrl_clear;
    logic pll_loaded;
    logic [4:0] ref_div;
    logic [1:0] out_div;
    logic pll_normal;
    logic [7:0] mult;
    logic remap;
    logic [3:0] cause;
    logic [31:0] identity;
    logic [31:0] pll_word;
    logic [31:0] next_prdata;
    logic next_slverr;
    logic access;
    logic wr_fire;
    logic wr_ok;

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    strap_sampler u_sampler (
        .clk (REF_CLK),
        .rst (SYS_RST),
        .addr_pins (ADDR_STRAP),
        .byte_order_pin (BYTE_ORDER_STRAP),
        .debug_sel_pin (DEBUG_MODE_SELECT),
        .soft_n_pin (SOFT_RESET_PIN_N),
        .wdog_pin (WATCHDOG_TIMEOUT),
        .cfg (cfg.sampler)
    );

    clock_enable_divider #(
        .CPU_DIV (boot_cfg_pkg::CPU_DIV),
        .BUS_DIV (boot_cfg_pkg::BUS_DIV)
    ) u_divider (
        .clk (REF_CLK),
        .rst (SYS_RST),
        .cfg (cfg.divider)
    );

    // ------------------------------------------------------------
    // reset requests
    // ------------------------------------------------------------
    // watchdog edge, so a stuck timeout line gives one reset only
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            wdog_q <= 1'b0;
        end else begin
            wdog_q <= cfg.wdog;
        end
    end

    assign soft_req = !cfg.soft_n;
    assign wdog_req = cfg.wdog && !wdog_q;
    assign pll_req = wr_ok && (PADDR == boot_cfg_pkg::PLL_SETUP_ADDR);
    assign any_req = soft_req || wdog_req || pll_req;
    assign ctrl_clear = (state == RUNNING) && any_req;

    // ------------------------------------------------------------
    // internal reset sequencer
    // ------------------------------------------------------------
    // hold time counts only once the soft pin has let go
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            state <= HOLDING;
            hold_count <= '0;
            retain <= 1'b0;
        end else begin
            case (state)
                RUNNING: begin
                    if (any_req) begin
                        state <= HOLDING;
                        hold_count <= '0;
                        retain <= !pll_req;
                    end
                end
                HOLDING: begin
                    if (soft_req) begin
                        hold_count <= '0;
                    end else if (hold_count == 16'(HOLD_CYCLES - 1)) begin
                        state <= RUNNING;
                        retain <= 1'b1;
                    end else begin
                        hold_count <= hold_count + 16'h0001;
                    end
                end
                default: begin
                    state <= HOLDING;
                    hold_count <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // pll setup register
    // ------------------------------------------------------------
    // strap fields reload only after a hard reset; soft and watchdog resets keep them, a pll write replaces them
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            pll_loaded <= 1'b0;
            ref_div <= '0;
            out_div <= '0;
            pll_normal <= 1'b0;
            mult <= boot_cfg_pkg::MULT_RESET;
        end else if (!pll_loaded && cfg.strap_valid) begin
            pll_loaded <= 1'b1;
            ref_div <= cfg.addr_strap[boot_cfg_pkg::REF_STRAP_LSB +: 5]
                ^ boot_cfg_pkg::REF_STRAP_XOR;
            out_div <= ~cfg.addr_strap[boot_cfg_pkg::OUT_STRAP_LSB +: 2];
            pll_normal <= cfg.addr_strap[boot_cfg_pkg::PLL_MODE_STRAP];
        end else if (pll_req) begin
            ref_div <= PWDATA[boot_cfg_pkg::PLL_REF_LSB +: 5];
            out_div <= PWDATA[boot_cfg_pkg::PLL_OUT_LSB +: 2];
            pll_normal <= PWDATA[boot_cfg_pkg::PLL_NORMAL_BIT];
            mult <= PWDATA[boot_cfg_pkg::PLL_MULT_LSB +: 8];
        end
    end

    // ------------------------------------------------------------
    // remap control
    // ------------------------------------------------------------
    // any reset sends the decoder back to boot mapping
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST || ctrl_clear) begin
            remap <= 1'b0;
        end else if (wr_ok && (PADDR == boot_cfg_pkg::REMAP_CTRL_ADDR)) begin
            remap <= PWDATA[boot_cfg_pkg::REMAP_BIT];
        end
    end

    // ------------------------------------------------------------
    // reset cause, write one to clear, a new cause wins
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            cause <= 4'h1;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_ok && (PADDR == boot_cfg_pkg::RESET_CAUSE_ADDR) && PWDATA[i]) begin
                    cause[i] <= 1'b0;
                end
            end
            if (ctrl_clear && soft_req) begin
                cause[boot_cfg_pkg::CAUSE_SOFT] <= 1'b1;
            end
            if (ctrl_clear && pll_req) begin
                cause[boot_cfg_pkg::CAUSE_PLL] <= 1'b1;
            end
            if (ctrl_clear && wdog_req) begin
                cause[boot_cfg_pkg::CAUSE_WDOG] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // read words
    // ------------------------------------------------------------
    // identity is built from straps frozen at hard reset release
    always_comb begin
        identity = '0;
        identity[boot_cfg_pkg::ID_PLATFORM_LSB +: 4] =
            cfg.addr_strap[boot_cfg_pkg::PLATFORM_STRAP_LSB +: 4];
        identity[boot_cfg_pkg::ID_VARIANT_LSB +: 4] =
            cfg.addr_strap[boot_cfg_pkg::VARIANT_STRAP_LSB +: 4];
        identity[boot_cfg_pkg::ID_MEMCFG_LSB +: 3] =
            cfg.addr_strap[boot_cfg_pkg::MEMCFG_STRAP_LSB +: 3];
    end

    always_comb begin
        pll_word = '0;
        pll_word[boot_cfg_pkg::PLL_REF_LSB +: 5] = ref_div;
        pll_word[boot_cfg_pkg::PLL_OUT_LSB +: 2] = out_div;
        pll_word[boot_cfg_pkg::PLL_NORMAL_BIT] = pll_normal;
        pll_word[boot_cfg_pkg::PLL_MULT_LSB +: 8] = mult;
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    // unmapped address, identity write or access during reset: error
    always_comb begin
        next_prdata = '0;
        next_slverr = 1'b0;
        case (PADDR)
            boot_cfg_pkg::PLL_SETUP_ADDR: begin
                next_prdata = pll_word;
            end
            boot_cfg_pkg::IDENTITY_ADDR: begin
                next_prdata = identity;
                next_slverr = PWRITE;
            end
            boot_cfg_pkg::REMAP_CTRL_ADDR: begin
                next_prdata[boot_cfg_pkg::REMAP_BIT] = remap;
            end
            boot_cfg_pkg::RESET_CAUSE_ADDR: begin
                next_prdata[3:0] = cause;
            end
            default: begin
                next_slverr = 1'b1;
            end
        endcase
        if (state != RUNNING) begin
            next_slverr = 1'b1;
        end
        if (next_slverr) begin
            next_prdata = '0;
        end
    end

    assign access = PSEL && PENABLE && PREADY;
    assign wr_fire = access && PWRITE;
    assign wr_ok = wr_fire && !PSLVERR;

    // answer is prepared in the setup cycle, one access cycle, no waits
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            PREADY <= 1'b0;
            PRDATA <= '0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PRDATA <= (PSEL && !PENABLE && !PWRITE) ? next_prdata : 32'h0000_0000;
            PSLVERR <= PSEL && !PENABLE && next_slverr;
        end
    end

    // ------------------------------------------------------------
    // boot configuration outputs
    // ------------------------------------------------------------
    // straps stay frozen through soft, pll and watchdog resets
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            BIG_ENDIAN <= 1'b0;
            DEBUG_MODE <= 1'b0;
            SCAN_TEST_ENABLE <= 1'b0;
        end else begin
            BIG_ENDIAN <= cfg.strap_valid && cfg.byte_order;
            DEBUG_MODE <= cfg.strap_valid && !cfg.debug_sel;
            SCAN_TEST_ENABLE <= cfg.strap_valid && !cfg.debug_sel;
        end
    end

    // pll fields to the pll macro
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            REF_DIVIDER <= '0;
            OUTPUT_DIVIDER <= '0;
            PLL_NORMAL <= 1'b0;
            FEEDBACK_MULTIPLIER <= boot_cfg_pkg::MULT_RESET;
        end else begin
            REF_DIVIDER <= ref_div;
            OUTPUT_DIVIDER <= out_div;
            PLL_NORMAL <= pll_normal;
            FEEDBACK_MULTIPLIER <= mult;
        end
    end

    // ------------------------------------------------------------
    // reset and memory map outputs
    // ------------------------------------------------------------
    // pin multiplexing returns to default only under the hard reset pin
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            INTERNAL_RESET <= 1'b1;
            SDRAM_RETAIN <= 1'b0;
            PINMUX_RESET <= 1'b1;
            BOOT_REMAP <= 1'b0;
            FLASH_BASE <= boot_cfg_pkg::FLASH_BOOT_BASE;
        end else begin
            INTERNAL_RESET <= (state == HOLDING) || ctrl_clear;
            SDRAM_RETAIN <= ctrl_clear ? !pll_req : retain;
            PINMUX_RESET <= 1'b0;
            BOOT_REMAP <= remap && !ctrl_clear;
            FLASH_BASE <= (remap && !ctrl_clear) ? boot_cfg_pkg::FLASH_RUN_BASE
                : boot_cfg_pkg::FLASH_BOOT_BASE;
        end
    end

    // ------------------------------------------------------------
    // rate enables
    // ------------------------------------------------------------
    // one cycle late against the divider, phase relation is kept
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            IFACE_CLK_EN <= 1'b0;
            CPU_CLK_EN <= 1'b0;
            BUS_CLK_EN <= 1'b0;
        end else begin
            IFACE_CLK_EN <= cfg.iface_en;
            CPU_CLK_EN <= cfg.cpu_en;
            BUS_CLK_EN <= cfg.bus_en;
        end
    end
endmodule

// *** bench/boot_cfg_asserts.sv ***
// concurrent checks on the boot configuration block ports
`timescale 1ns/1ps
module boot_cfg_asserts (
    // clock, reset and apb request
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    // watched outputs
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic BIG_ENDIAN,
    input wire logic DEBUG_MODE,
    input wire logic SCAN_TEST_ENABLE,
    input wire logic [7:0] FEEDBACK_MULTIPLIER,
    input wire logic INTERNAL_RESET,
    input wire logic SDRAM_RETAIN,
    input wire logic PINMUX_RESET,
    input wire logic BOOT_REMAP,
    input wire logic [31:0] FLASH_BASE,
    input wire logic CPU_CLK_EN,
    input wire logic BUS_CLK_EN
);
    logic [3:0] up_count;
    logic pll_wr;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    // edges since hard reset; straps are only settled after the sync chain
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            up_count <= 4'h0;
        end else if (up_count != 4'hF) begin
            up_count <= up_count + 4'h1;
        end
    end
    // accepted write to the pll register at its access edge
    assign pll_wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR
        && (PADDR == boot_cfg_pkg::PLL_SETUP_ADDR);
    sequence s_settled;
        up_count > 4'h6;
    endsequence
    sequence s_hold;
        INTERNAL_RESET [*8];
    endsequence
    a_scan_debug: assert property (SCAN_TEST_ENABLE == DEBUG_MODE)
        else $error("scan enable differs from debug mode");
    // register load at the access edge, output flop one edge later
    a_mult_sw: assert property ($changed(FEEDBACK_MULTIPLIER) |-> $past(pll_wr, 2))
        else $error("multiplier moved without a write");
    a_pll_reset: assert property (pll_wr |=> s_hold)
        else $error("no internal reset after pll write");
    a_pll_sdram: assert property (pll_wr |=> !SDRAM_RETAIN)
        else $error("memory kept over pll update");
    a_remap_base: assert property (FLASH_BASE ==
        (BOOT_REMAP ? boot_cfg_pkg::FLASH_RUN_BASE : boot_cfg_pkg::FLASH_BOOT_BASE))
        else $error("flash base does not follow remap");
    a_straps_held: assert property (s_settled |->
        $stable(BIG_ENDIAN) && $stable(DEBUG_MODE))
        else $error("strap output moved without hard reset");
    a_pinmux_done: assert property (s_settled |-> !PINMUX_RESET)
        else $error("pin mux reset outside hard reset");
    a_cpu_rate: assert property (CPU_CLK_EN |=> !CPU_CLK_EN ##1 CPU_CLK_EN)
        else $error("processor enable not every second cycle");
    a_bus_rate: assert property (BUS_CLK_EN |-> CPU_CLK_EN ##1
        !BUS_CLK_EN [*3] ##1 BUS_CLK_EN)
        else $error("bus enable not every fourth cycle");
endmodule
bind boot_strap_and_reset_config boot_cfg_asserts chk (.*);

// *** bench/board_straps.sv ***
// board strap resistors and external reset sources for the boot block
`timescale 1ns/1ps
module board_straps (
    // fitting choices from the bench
    input wire logic [19:0] pull_down,
    input wire logic byte_low,
    input wire logic debug_low,
    input wire logic soft_hold,
    input wire logic wdog_fire,
    // strap and reset pins
    output logic [19:0] addr_pins,
    output logic byte_pin,
    output logic debug_pin,
    output logic soft_n_pin,
    output logic wdog_pin
);
    // straps float high unless a pull-down is fitted or the pin is tied low
    assign addr_pins = ~pull_down;
    assign byte_pin = ~byte_low;
    assign debug_pin = ~debug_low;
    // soft reset idles high, watchdog idles low
    assign soft_n_pin = ~soft_hold;
    assign wdog_pin = wdog_fire;
endmodule

// *** bench/testbench.sv ***
// self-checking bench for strap capture, identity, pll and reset behaviour
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin fail_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end
module testbench;
    logic REF_CLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [31:0] PADDR = 32'h0000_0000, PWDATA = 32'h0000_0000, PRDATA, FLASH_BASE, rd;
    wire logic [19:0] ADDR_STRAP;
    wire logic BYTE_ORDER_STRAP, DEBUG_MODE_SELECT, SOFT_RESET_PIN_N, WATCHDOG_TIMEOUT;
    logic PREADY, PSLVERR, BIG_ENDIAN, DEBUG_MODE, SCAN_TEST_ENABLE, PLL_NORMAL, er;
    logic INTERNAL_RESET, SDRAM_RETAIN, PINMUX_RESET, BOOT_REMAP, IFACE_CLK_EN;
    logic CPU_CLK_EN, BUS_CLK_EN, byte_low = 1'b0, debug_low = 1'b0;
    logic soft_hold = 1'b0, wdog_fire = 1'b0;
    logic [4:0] REF_DIVIDER;
    logic [1:0] OUTPUT_DIVIDER;
    logic [7:0] FEEDBACK_MULTIPLIER;
    logic [19:0] pins = 20'h9_63FD;
    int fail_count = 0, n_tests = 0;
    // board straps drive the pins; the bench only picks the fitting
    board_straps straps (.pull_down(~pins), .byte_low(byte_low), .debug_low(debug_low),
        .soft_hold(soft_hold), .wdog_fire(wdog_fire), .addr_pins(ADDR_STRAP),
        .byte_pin(BYTE_ORDER_STRAP), .debug_pin(DEBUG_MODE_SELECT),
        .soft_n_pin(SOFT_RESET_PIN_N), .wdog_pin(WATCHDOG_TIMEOUT));
    boot_strap_and_reset_config uut (.*);
    initial begin
        forever #4 REF_CLK = ~REF_CLK;
    end
    // tests need about 700 cycles; 12500 means something hung
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // one apb transfer entered after a rising edge; an idle edge follows
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        // no local limit: only the bench watchdog ends a stuck wait
        do begin
            @(posedge REF_CLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge REF_CLK);
    endtask
    // wait out an internal reset hold, bounded well past its length
    task automatic wait_idle();
        int n;
        n = 0;
        while (INTERNAL_RESET !== 1'b0 && n < 400) begin
            @(posedge REF_CLK);
            n++;
        end
        `CHK("hold end", 1'b0, INTERNAL_RESET)
    endtask
    function automatic logic [31:0] ident(input logic [19:0] p);
        return {17'h0_0000, p[19:17], p[12:9], p[16:13], 4'h0};
    endfunction
    // power-up straps, identity, refusals, remap, soft, watchdog, pll, repower
    initial begin
        repeat (3) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
        wait_idle();
        `CHK("big", 1'b1, BIG_ENDIAN)
        `CHK("scan", 1'b0, SCAN_TEST_ENABLE)
        `CHK("ref div", 5'h05, REF_DIVIDER)
        `CHK("out div", 2'h0, OUTPUT_DIVIDER)
        `CHK("normal", 1'b1, PLL_NORMAL)
        `CHK("iface en", 1'b1, IFACE_CLK_EN)
        apb(1'b0, boot_cfg_pkg::IDENTITY_ADDR, 32'h0000_0000);
        `CHK("identity", ident(20'h9_63FD), rd)
        apb(1'b0, boot_cfg_pkg::PLL_SETUP_ADDR, 32'h0000_0000);
        `CHK("pll read", 32'h0000_3C85, rd)
        apb(1'b1, boot_cfg_pkg::IDENTITY_ADDR, 32'hFFFF_FFFF);
        `CHK("id write", 1'b1, er)
        apb(1'b0, 32'hA090_0300, 32'h0000_0000);
        `CHK("unmapped", 1'b1, er)
        `CHK("boot base", 32'h0000_0000, FLASH_BASE)
        apb(1'b1, boot_cfg_pkg::REMAP_CTRL_ADDR, 32'h0000_0001);
        @(posedge REF_CLK);
        `CHK("run base", 32'h5000_0000, FLASH_BASE)
        `CHK("remap on", 1'b1, BOOT_REMAP)
        $display("test power-up done");
        pins <= 20'h6_A00E;
        byte_low <= 1'b1;
        soft_hold <= 1'b1;
        repeat (6) @(posedge REF_CLK);
        `CHK("soft keeps", 1'b1, SDRAM_RETAIN)
        soft_hold <= 1'b0;
        wait_idle();
        `CHK("remap clr", 1'b0, BOOT_REMAP)
        `CHK("endian kept", 1'b1, BIG_ENDIAN)
        // hard bit from power-up plus the soft bit just raised
        apb(1'b0, boot_cfg_pkg::RESET_CAUSE_ADDR, 32'h0000_0000);
        `CHK("cause", 32'h0000_0003, rd)
        wdog_fire <= 1'b1;
        repeat (6) @(posedge REF_CLK);
        wdog_fire <= 1'b0;
        `CHK("wdog hold", 1'b1, INTERNAL_RESET)
        `CHK("wdog keeps", 1'b1, SDRAM_RETAIN)
        // accesses inside the hold are refused with zero data
        apb(1'b0, boot_cfg_pkg::PLL_SETUP_ADDR, 32'h0000_0000);
        `CHK("busy err", 1'b1, er)
        `CHK("busy data", 32'h0000_0000, rd)
        wait_idle();
        `CHK("ref kept", 5'h05, REF_DIVIDER)
        apb(1'b1, boot_cfg_pkg::PLL_SETUP_ADDR, 32'h0000_20A7);
        `CHK("pll lose", 1'b0, SDRAM_RETAIN)
        wait_idle();
        `CHK("mult new", 8'h20, FEEDBACK_MULTIPLIER)
        $display("test soft resets done");
        debug_low <= 1'b1;
        SYS_RST <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
        wait_idle();
        `CHK("little", 1'b0, BIG_ENDIAN)
        `CHK("debug scan", 1'b1, SCAN_TEST_ENABLE)
        apb(1'b0, boot_cfg_pkg::PLL_SETUP_ADDR, 32'h0000_0000);
        `CHK("pll strap", 32'h0000_3C76, rd)
        apb(1'b0, boot_cfg_pkg::IDENTITY_ADDR, 32'h0000_0000);
        `CHK("identity 2", ident(20'h6_A00E), rd)
        $display("test hard reset done");
        close_out();
    end
endmodule
